// >>> rtl/passthru_port_map.svh
// named constants for the add-on pass-thru and direct fifo port
`ifndef PASSTHRU_PORT_MAP_SVH
`define PASSTHRU_PORT_MAP_SVH
`define FIFO_DEPTH      8
`define FIFO_PTR_W      3
`define FIFO_CNT_W      4
`define DATA_W          32
`define HALF_W          16
`define BE_NONE         4'hf
`define REGION_NONE     2'h0
`define ADDR_RESET      32'h0000_0000
`define CNT_ZERO        4'h0
`define CNT_ONE         4'h1
`define PTR_ONE         3'h1
`define BUS_MODE_32     1'b0
`endif

// >>> rtl/passthru_port_pkg.sv
// types for the add-on pass-thru and direct fifo port
package passthru_port_pkg;
	typedef enum logic [1:0] {
		PT_IDLE,
		PT_ATTN,
		PT_DONE
	} pt_state_t;
endpackage

// >>> rtl/local_fifo.sv
// small synchronous fifo used for both transfer directions
`timescale 1ns/1ns
`include "passthru_port_map.svh"
module local_fifo (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               push,
	input  wire logic [31:0]        push_data,
	input  wire logic               pop,
	output logic      [31:0]        pop_data,
	output logic                    full,
	output logic                    empty
);
	typedef struct packed {
		logic [`FIFO_PTR_W-1:0] wr;
		logic [`FIFO_PTR_W-1:0] rd;
		logic [`FIFO_CNT_W-1:0] cnt;
	} fifo_st_t;

	fifo_st_t        st_r;
	fifo_st_t        st_nxt;
	logic [31:0]     mem [`FIFO_DEPTH];
	logic            do_push;
	logic            do_pop;

	// ============================================================
	// flags and qualified strobes
	assign full     = (st_r.cnt == `FIFO_DEPTH);
	assign empty    = (st_r.cnt == `CNT_ZERO);
	assign do_push  = push && !full;  // writes to a full fifo are dropped
	assign do_pop   = pop && !empty;
	assign pop_data = mem[st_r.rd];

	// next pointers and count
	always_comb begin
		st_nxt = st_r;
		if (do_push) begin
			st_nxt.wr = st_r.wr + `PTR_ONE;
		end
		if (do_pop) begin
			st_nxt.rd = st_r.rd + `PTR_ONE;
		end
		if (do_push && !do_pop) begin
			st_nxt.cnt = st_r.cnt + `CNT_ONE;
		end else if (do_pop && !do_push) begin
			st_nxt.cnt = st_r.cnt - `CNT_ONE;
		end
	end

	// storage carries no reset; only the pointers and count need a defined value
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[st_r.wr] <= push_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // local_fifo

// >>> rtl/addon_passthru_fifo_port.sv
// add-on side pass-thru handshake and direct fifo strobe port
// How it works
// - attention goes low when a bus cycle hits a pass-thru region.
// - burst output goes low when the pass-thru cycle is a burst.
// - two-bit region number names one of four regions, valid with attention.
// - four active-low byte enables mark active bytes, valid with attention.
// - address read-out input drives the 32-bit pass-thru address on data bus.
// - direction output tells read or write, valid with attention.
// - system reset output is a buffered bus reset, also software driven.
// - buffered bus clock output copies the bus clock.
// - interrupt request output goes low on a significant internal event.
// - float input low puts every output into high impedance.
// - boot select high means serial or no boot memory, low byte-wide.
// - write strobe pushes bus data into the outbound fifo directly.
// - read strobe drives inbound fifo data onto the bus directly.
// - outbound full output shows whether more data fits; low requests writes.
// - inbound empty output shows whether data waits; low requests reads.
// - read data leaves the bus as soon as the read strobe rises.
`timescale 1ns/1ns
`include "passthru_port_map.svh"
module addon_passthru_fifo_port
	import passthru_port_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	// internal side: pass-thru request from the bus target
	input  wire logic               pt_req,
	input  wire logic [1:0]         pt_req_region,
	input  wire logic [3:0]         pt_req_byte_en_n,
	input  wire logic               pt_req_write,
	input  wire logic               pt_req_burst,
	input  wire logic [31:0]        pt_req_addr,
	output logic                    pt_req_taken,
	output logic                    pt_done,
	// internal side: fifo streams and events
	input  wire logic               in_push,
	input  wire logic [31:0]        in_push_data,
	output logic                    in_full,
	input  wire logic               out_pop,
	output logic [31:0]             out_pop_data,
	output logic                    out_valid,
	input  wire logic               bus_reset_n,
	input  wire logic               soft_reset,
	input  wire logic               event_pulse,
	input  wire logic               event_clear,
	output logic                    boot_byte_wide,
	// add-on pins
	output logic                    passthru_attention_n,
	output logic                    passthru_burst_n,
	output logic [1:0]              passthru_region_id,
	output logic [3:0]              passthru_byte_en_n,
	output logic                    passthru_direction,
	input  wire logic               passthru_ready_n,
	input  wire logic               passthru_addr_readout_n,
	input  wire logic               bus_width_16,
	input  wire logic               direct_fifo_write_n,
	input  wire logic               direct_fifo_read_n,
	input  wire logic [31:0]        dq_in,
	output logic [31:0]             dq_out,
	output logic [31:0]             dq_oe,
	output logic                    outbound_fifo_full,
	output logic                    inbound_fifo_empty,
	output logic                    outbound_fifo_empty_flag,
	output logic                    local_system_reset_n,
	output logic                    buffered_bus_clock,
	output logic                    irq_n,
	input  wire logic               output_float_n,
	output logic                    outputs_oe,
	input  wire logic               boot_device_serial
);
	typedef struct packed {
		pt_state_t   state;
		logic        attn_n;
		logic        burst_n;
		logic [1:0]  region;
		logic [3:0]  be_n;
		logic        dir;
		logic [31:0] addr;
		logic        taken;
		logic        done;
		logic        irq_n;
		logic        wfull;
		logic        rempty;
		logic        wempty;
		logic        oe;
		logic        boot_bw;
		logic        wr_prev_n;
		logic        rd_prev_n;
		logic        hi_half;
		logic [15:0] low_half;
	} port_st_t;

	port_st_t    st_r;
	port_st_t    st_nxt;
	logic        ib_full, ib_empty, ob_full, ob_empty;
	logic [31:0] ib_data;
	logic [31:0] ob_data;
	logic        ib_pop, ob_push;
	logic [31:0] ob_push_data;
	logic        local_system_reset_n_r;

	// 16-bit mode keeps only the low half of the bus
	function automatic logic [31:0] width_mask(input logic narrow);
		width_mask = narrow ? {{`HALF_W{1'b0}}, {`HALF_W{1'b1}}} : {`DATA_W{1'b1}};
	endfunction

	// ============================================================
	// fifos: inbound feeds add-on reads, outbound takes add-on writes
	local_fifo u_inbound (
		.clk       (clk),
		.rst_n     (rst_n),
		.push      (in_push),
		.push_data (in_push_data),
		.pop       (ib_pop),
		.pop_data  (ib_data),
		.full      (ib_full),
		.empty     (ib_empty)
	);

	local_fifo u_outbound (
		.clk       (clk),
		.rst_n     (rst_n),
		.push      (ob_push),
		.push_data (ob_push_data),
		.pop       (out_pop),
		.pop_data  (ob_data),
		.full      (ob_full),
		.empty     (ob_empty)
	);

	// ============================================================
	// pass-thru handshake, fifo strobes and status
	always_comb begin
		st_nxt           = st_r;
		st_nxt.taken     = 1'b0;
		st_nxt.done      = 1'b0;
		st_nxt.wr_prev_n = direct_fifo_write_n;
		st_nxt.rd_prev_n = direct_fifo_read_n;
		ib_pop           = 1'b0;
		ob_push          = 1'b0;
		ob_push_data     = dq_in & width_mask(bus_width_16);
		case (st_r.state)
			PT_IDLE: begin
				if (pt_req) begin
					st_nxt.state   = PT_ATTN;
					st_nxt.attn_n  = 1'b0;
					st_nxt.burst_n = !pt_req_burst;
					st_nxt.region  = pt_req_region;
					st_nxt.be_n    = pt_req_byte_en_n;
					st_nxt.dir     = pt_req_write;
					st_nxt.addr    = pt_req_addr;
					st_nxt.taken   = 1'b1;
				end
			end
			PT_ATTN: begin
				// everything holds until ready is seen
				if (!passthru_ready_n) begin
					st_nxt.state   = PT_DONE;
					st_nxt.attn_n  = 1'b1;
					st_nxt.burst_n = 1'b1;
					st_nxt.be_n    = `BE_NONE;
					st_nxt.region  = `REGION_NONE;
					st_nxt.dir     = 1'b0;
					st_nxt.done    = 1'b1;
				end
			end
			PT_DONE: begin
				// one idle cycle so a held ready is not taken twice
				st_nxt.state = PT_IDLE;
			end
			default: begin
				st_nxt.state = PT_IDLE;
			end
		endcase
		// one word per strobe, one half-word on the 16-bit bus: act on the falling edge only
		if (!direct_fifo_write_n && st_r.wr_prev_n) begin
			if (bus_width_16 && !st_r.hi_half) begin
				st_nxt.low_half = dq_in[15:0];
				st_nxt.hi_half  = 1'b1;
			end else begin
				ob_push = 1'b1;
				if (bus_width_16) begin
					ob_push_data   = {dq_in[15:0], st_r.low_half};
					st_nxt.hi_half = 1'b0;
				end
			end
		end
		// the read word leaves the fifo when the strobe is released
		if (direct_fifo_read_n && !st_r.rd_prev_n) begin
			ib_pop = 1'b1;
		end
		st_nxt.wfull   = ob_full;
		st_nxt.wempty  = ob_empty;
		st_nxt.rempty  = ib_empty;
		st_nxt.oe      = output_float_n;
		st_nxt.boot_bw = !boot_device_serial;
		// sticky event line, event wins over clear
		if (event_pulse) begin
			st_nxt.irq_n = 1'b0;
		end else if (event_clear) begin
			st_nxt.irq_n = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r           <= '0;
			st_r.state     <= PT_IDLE;
			st_r.attn_n    <= 1'b1;
			st_r.burst_n   <= 1'b1;
			st_r.be_n      <= `BE_NONE;
			st_r.addr      <= `ADDR_RESET;
			st_r.irq_n     <= 1'b1;
			st_r.rempty    <= 1'b1;
			st_r.wempty    <= 1'b1;
			st_r.wr_prev_n <= 1'b1;
			st_r.rd_prev_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// bus reset asserts with no clock; its release and soft reset wait for a clock edge
	always_ff @(posedge clk or negedge bus_reset_n) begin
		if (!bus_reset_n) begin
			local_system_reset_n_r <= 1'b0;
		end else begin
			local_system_reset_n_r <= !soft_reset;
		end
	end

	// ============================================================
	// pin drive; data bus is combinational so read release is immediate
	always_comb begin
		dq_out = `ADDR_RESET;
		dq_oe  = `ADDR_RESET;
		if (!passthru_addr_readout_n) begin
			dq_out = st_r.addr;
			dq_oe  = {`DATA_W{output_float_n}};
		end else if (!direct_fifo_read_n) begin
			dq_out = ib_data & width_mask(bus_width_16);
			dq_oe  = width_mask(bus_width_16) & {`DATA_W{output_float_n}};
		end
	end

	assign passthru_attention_n     = st_r.attn_n;
	assign passthru_burst_n         = st_r.burst_n;
	assign passthru_region_id       = st_r.region;
	assign passthru_byte_en_n       = st_r.be_n;
	assign passthru_direction       = st_r.dir;
	assign outbound_fifo_full       = st_r.wfull;
	assign inbound_fifo_empty       = st_r.rempty;
	assign outbound_fifo_empty_flag = st_r.wempty;
	assign irq_n                    = st_r.irq_n;
	assign outputs_oe               = st_r.oe;
	assign boot_byte_wide           = st_r.boot_bw;
	assign local_system_reset_n     = local_system_reset_n_r;
	assign buffered_bus_clock       = clk;
	assign pt_req_taken             = st_r.taken;
	assign pt_done                  = st_r.done;
	assign in_full                  = ib_full;
	assign out_pop_data             = ob_data;
	assign out_valid                = !ob_empty;
endmodule // addon_passthru_fifo_port

// >>> tb/addon_logic_model.sv
// add-on logic model that answers pass-thru attention with ready
`timescale 1ns/1ns
module addon_logic_model (
	input  wire logic       clk,
	input  wire logic       passthru_attention_n,
	input  wire logic [3:0] delay,
	output logic            passthru_ready_n
);
	logic [3:0] wait_r  = 4'h0;
	logic       ready_r = 1'b1;
	assign passthru_ready_n = ready_r;
	// ready is held until attention drops, so it is never missed
	always @(posedge clk) begin
		if (passthru_attention_n) begin
			wait_r <= 4'h0;
			ready_r <= 1'b1;
		end else if (wait_r >= delay) begin
			ready_r <= 1'b0;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule // addon_logic_model

// >>> tb/addon_port_checker.sv
// concurrent checks on the add-on port pins
`timescale 1ns/1ns
module addon_port_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        pt_req_taken,
	input wire logic        pt_done,
	input wire logic        passthru_attention_n,
	input wire logic        passthru_burst_n,
	input wire logic [1:0]  passthru_region_id,
	input wire logic [3:0]  passthru_byte_en_n,
	input wire logic        passthru_direction,
	input wire logic        passthru_ready_n,
	input wire logic        passthru_addr_readout_n,
	input wire logic        direct_fifo_read_n,
	input wire logic [31:0] dq_oe,
	input wire logic        event_pulse,
	input wire logic        irq_n,
	input wire logic        bus_reset_n,
	input wire logic        local_system_reset_n,
	input wire logic        buffered_bus_clock,
	input wire logic        outputs_oe,
	input wire logic        output_float_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// =====================================
	// pass-thru handshake
	attn_on_take_a: assert property (pt_req_taken |-> !passthru_attention_n)
		else $error("attention not low at take");
	fields_hold_a: assert property (!passthru_attention_n && passthru_ready_n |=>
		!passthru_attention_n && $stable({passthru_burst_n, passthru_region_id,
		passthru_byte_en_n, passthru_direction})) else $error("fields moved");
	ready_end_a: assert property (!passthru_attention_n && !passthru_ready_n |=>
		passthru_attention_n && pt_done ##1 passthru_attention_n) else $error("no release");
	be_idle_a: assert property (passthru_attention_n |-> passthru_byte_en_n == 4'hf)
		else $error("enables active while idle");
	// =====================================
	// data bus and side pins
	readout_drive_a: assert property (!passthru_addr_readout_n && direct_fifo_read_n
		&& outputs_oe |-> dq_oe == 32'hffff_ffff) else $error("address not driven");
	read_release_a: assert property (direct_fifo_read_n && passthru_addr_readout_n
		|-> dq_oe == 32'h0) else $error("bus still driven");
	float_off_a: assert property (!output_float_n |=> !outputs_oe)
		else $error("outputs not floated");
	irq_set_a: assert property (event_pulse |=> !irq_n)
		else $error("interrupt not raised");
	local_system_reset_n_copy_a: assert property (!bus_reset_n |-> !local_system_reset_n)
		else $error("system reset not passed");
	clock_copy_a: assert property (@(negedge clk) buffered_bus_clock)
		else $error("clock copy low before falling edge");
	clock_low_a: assert property (!buffered_bus_clock)
		else $error("clock copy high before rising edge");
	cover property (!passthru_attention_n && passthru_ready_n [*3]);
	cover property (!passthru_addr_readout_n);
	cover property ($fell(direct_fifo_read_n));
endmodule // addon_port_checker
bind addon_passthru_fifo_port addon_port_checker addon_port_checker_inst (.clk, .rst_n,
	.pt_req_taken, .pt_done, .passthru_attention_n, .passthru_burst_n, .passthru_region_id,
	.passthru_byte_en_n, .passthru_direction, .passthru_ready_n, .passthru_addr_readout_n,
	.direct_fifo_read_n, .dq_oe, .event_pulse, .irq_n, .bus_reset_n, .local_system_reset_n,
	.buffered_bus_clock, .outputs_oe, .output_float_n);

// >>> tb/addon_passthru_fifo_port_test.sv
// self-checking bench for the add-on pass-thru and direct fifo port
`timescale 1ns/1ns
module addon_passthru_fifo_port_test;
	logic clk, rst_n, pt_req, pt_req_write, pt_req_burst, pt_req_taken, pt_done, in_push;
	logic in_full, out_pop, out_valid, bus_reset_n, soft_reset, event_pulse, event_clear;
	logic boot_byte_wide, passthru_attention_n, passthru_burst_n, passthru_direction;
	logic passthru_ready_n, passthru_addr_readout_n, bus_width_16, direct_fifo_write_n;
	logic direct_fifo_read_n, outbound_fifo_full, inbound_fifo_empty, outbound_fifo_empty_flag;
	logic local_system_reset_n, buffered_bus_clock, irq_n, output_float_n, outputs_oe;
	logic boot_device_serial;
	logic [1:0]  pt_req_region, passthru_region_id;
	logic [3:0]  pt_req_byte_en_n, passthru_byte_en_n, dly;
	logic [31:0] pt_req_addr, in_push_data, out_pop_data, dq_in, dq_out, dq_oe;
	logic [15:0] seed;
	logic [7:0]  notes[$];
	logic [7:0]  shown;
	int          n_errors, cmp_count;
	addon_passthru_fifo_port addon_passthru_fifo_port_inst (.clk, .rst_n, .pt_req,
		.pt_req_region, .pt_req_byte_en_n, .pt_req_write, .pt_req_burst, .pt_req_addr,
		.pt_req_taken, .pt_done, .in_push, .in_push_data, .in_full, .out_pop, .out_pop_data,
		.out_valid, .bus_reset_n, .soft_reset, .event_pulse, .event_clear, .boot_byte_wide,
		.passthru_attention_n, .passthru_burst_n, .passthru_region_id, .passthru_byte_en_n,
		.passthru_direction, .passthru_ready_n, .passthru_addr_readout_n, .bus_width_16,
		.direct_fifo_write_n, .direct_fifo_read_n, .dq_in, .dq_out, .dq_oe,
		.outbound_fifo_full, .inbound_fifo_empty, .outbound_fifo_empty_flag,
		.local_system_reset_n, .buffered_bus_clock, .irq_n, .output_float_n, .outputs_oe,
		.boot_device_serial);
	addon_logic_model addon_logic_model_inst (.clk, .passthru_attention_n, .delay(dly),
		.passthru_ready_n);
	// =====================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic fifo_write(input logic [31:0] d);
		direct_fifo_write_n = 1'b0;
		dq_in = d;
		@(negedge clk);
		direct_fifo_write_n = 1'b1;
		@(negedge clk);
	endtask
	task automatic fifo_read(input logic [31:0] exp);
		direct_fifo_read_n = 1'b0;
		#1 check(dq_out, exp);
		@(negedge clk);
		direct_fifo_read_n = 1'b1;
		#1 check(dq_oe, 32'h0);
		@(negedge clk);
	endtask
	task finish_test;
		$display("comparisons %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// =====================================
	// clock, watchdog and result monitor
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		finish_test;
	end
	// oldest note is compared whenever a request is shown on the pins
	// pins of a taken request, packed in the order of the notes
	assign shown = {passthru_region_id, passthru_byte_en_n, passthru_direction, passthru_burst_n};
	always @(negedge clk) if (pt_req_taken === 1'b1) begin
		check(shown, notes.pop_front());
	end
	// =====================================
	// stimulus
	initial begin
		{rst_n, pt_req, pt_req_write, pt_req_burst, in_push, out_pop, soft_reset} = '0;
		{event_pulse, event_clear, bus_width_16, dly, pt_req_region} = '0;
		{bus_reset_n, passthru_addr_readout_n, direct_fifo_write_n, direct_fifo_read_n} = '1;
		{output_float_n, boot_device_serial, pt_req_byte_en_n} = '1;
		{pt_req_addr, in_push_data, dq_in, n_errors, cmp_count} = '0;
		seed = 16'h63ec;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		// every region, prompt and slow ready
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			dly = i[3:0] & 4'h5;
			{pt_req_write, pt_req_burst, pt_req_byte_en_n} = seed[5:0];
			pt_req_region = i[1:0];
			pt_req_addr = {seed, ~seed};
			notes.push_back({i[1:0], seed[3:0], seed[5], ~seed[4]});
			// request stays pending until taken; the done cycle refuses it
			pt_req = 1'b1;
			@(negedge clk);
			for (int k = 0; k < 8 && pt_req_taken !== 1'b1; k++) @(negedge clk);
			check(pt_req_taken, 1'b1);
			pt_req = 1'b0;
			for (int k = 0; k < 30 && pt_done !== 1'b1; k++) @(negedge clk);
			check(pt_done, 1'b1);
		end
		passthru_addr_readout_n = 1'b0;
		#1 check(dq_out, {seed, ~seed});
		@(negedge clk);
		passthru_addr_readout_n = 1'b1;
		// outbound filled past full, then drained
		for (int i = 0; i < 9; i++) fifo_write(32'h1000_0000 + i);
		check(outbound_fifo_full, 1'b1);
		check(outbound_fifo_empty_flag, 1'b0);
		out_pop = 1'b1;
		for (int i = 0; i < 8; i++) begin
			check(out_pop_data, 32'h1000_0000 + i);
			@(negedge clk);
		end
		out_pop = 1'b0;
		check(out_valid, 1'b0);
		check(outbound_fifo_full, 1'b0);
		// half-word pairing on the narrow bus
		bus_width_16 = 1'b1;
		fifo_write(32'h0000_beef);
		fifo_write(32'h0000_cafe);
		check(out_pop_data, 32'hcafe_beef);
		out_pop = 1'b1;
		bus_width_16 = 1'b0;
		@(negedge clk);
		out_pop = 1'b0;
		// inbound filled then read out by strobe
		in_push = 1'b1;
		for (int i = 0; i < 8; i++) begin
			in_push_data = 32'ha5a5_0000 + i;
			@(negedge clk);
		end
		in_push = 1'b0;
		check(in_full, 1'b1);
		check(inbound_fifo_empty, 1'b0);
		for (int i = 0; i < 8; i++) fifo_read(32'ha5a5_0000 + i);
		@(negedge clk);
		check(inbound_fifo_empty, 1'b1);
		// narrow bus read drives only the low half, one word per strobe
		in_push = 1'b1;
		in_push_data = 32'h5a5a_1234;
		@(negedge clk);
		in_push = 1'b0;
		bus_width_16 = 1'b1;
		fifo_read(32'h0000_1234);
		bus_width_16 = 1'b0;
		// side pins
		event_pulse = 1'b1;
		boot_device_serial = 1'b0;
		@(negedge clk);
		event_pulse = 1'b0;
		event_clear = 1'b1;
		check(irq_n, 1'b0);
		check(boot_byte_wide, 1'b1);
		@(negedge clk);
		event_clear = 1'b0;
		output_float_n = 1'b0;
		@(negedge clk);
		check(irq_n, 1'b1);
		check(outputs_oe, 1'b0);
		// event and clear in one cycle: the event wins
		{event_pulse, event_clear} = 2'b11;
		@(negedge clk);
		{event_pulse, event_clear} = 2'b00;
		check(irq_n, 1'b0);
		soft_reset = 1'b1;
		bus_reset_n = 1'b0;
		#1 check(local_system_reset_n, 1'b0);
		@(negedge clk);
		bus_reset_n = 1'b1;
		@(negedge clk);
		check(local_system_reset_n, 1'b0);
		soft_reset = 1'b0;
		@(negedge clk);
		check(local_system_reset_n, 1'b1);
		finish_test;
	end
endmodule // addon_passthru_fifo_port_test
